//--- dmt_ctrl.sv
// Purpose: host-side sequencer that drives a DDR4 device through init with
//          gear-down, write leveling, single writes and refresh.
// Assumes: APB slave for orders and status; CK made here by a divider.
// Notes:   DDR command and strobe pins change only on the system cycle after a rising CK.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps

module dmt_ctrl
  import dmt_pkg::*;
#(
  parameter int CK_HALF    = CK_HALF_DEF,
  parameter int HAMMER_LIM = HAMMER_DEF
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // ddr command side
  output logic             ddr_ck,
  output logic             ddr_reset_n,
  output logic             ddr_cke,
  output logic             ddr_odt,
  output logic             ddr_cs_n,
  output logic             ddr_ras_n,
  output logic             ddr_cas_n,
  output logic             ddr_we_n,
  output logic      [1:0]  ddr_ba,
  output logic      [16:0] ddr_addr,
  // ddr strobe and leveling feedback
  output logic             ddr_dqs_o,
  output logic             ddr_dqs_oe,
  input  wire logic        ddr_dq_fb
);
  typedef struct packed {
    dmt_state_type st;
    logic [2:0]    op_req;
    logic [9:0]    tcnt;
    logic [9:0]    since_cke;
    logic [3:0]    odt_cnt;
    logic          rst_n;
    logic          cke;
    logic          odt;
    logic          cs_n;
    logic [2:0]    cmd;
    logic [1:0]    ba;
    logic [16:0]   addr;
    logic          dqs;
    logic          dqs_oe;
    logic          fb1;
    logic          fb2;
    logic          wl_sample;
    logic          gear_on;
    logic          hammer;
    logic [15:0]   last_row;
    logic [3:0]    same_cnt;
    logic [31:0]   cfg0;
    logic [31:0]   cfg1;
    logic [31:0]   cfg2;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } dmt_ctrl_type;

  dmt_ctrl_type s_reg;
  dmt_ctrl_type s_next;
  logic         ck_rise;

  // link clock divider
  dmt_ckgen #(
    .HALF    (CK_HALF)
  ) u_ckgen (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .ck      (ddr_ck),
    .ck_rise (ck_rise)
  );

  // configuration fields
  logic [4:0]  cas_write_latency;
  logic [4:0]  al;
  logic [3:0]  pl;
  logic [5:0]  wr;
  logic        pre2;
  logic        chop_fixed;
  logic        chop_otf;
  logic        par_en;
  logic        dll_off;
  logic        auto_pre;
  logic        slow;
  logic [7:0]  tmod;
  logic [9:0]  txpr;
  logic [9:0]  txs;
  logic [3:0]  cal_req;
  logic [9:0]  trfc;
  logic [15:0] row;

  assign cas_write_latency        = s_reg.cfg0[C0_CWL_POS +: 5];
  assign al         = s_reg.cfg0[C0_AL_POS +: 5];
  assign pl         = s_reg.cfg0[C0_PL_POS +: 4];
  assign wr         = s_reg.cfg0[C0_WR_POS +: 6];
  assign pre2       = s_reg.cfg0[C0_PRE2_POS];
  assign chop_fixed = s_reg.cfg0[C0_CHOPF_POS];
  assign chop_otf   = s_reg.cfg0[C0_CHOPO_POS];
  assign par_en     = s_reg.cfg0[C0_PAR_POS];
  assign dll_off    = s_reg.cfg0[C0_DLLO_POS];
  assign auto_pre   = s_reg.cfg0[C0_AP_POS];
  assign slow       = s_reg.cfg0[C0_SLOW_POS];
  assign tmod       = s_reg.cfg1[C1_TMOD_POS +: 8];
  assign txpr       = s_reg.cfg1[C1_TXPR_POS +: 10];
  assign txs        = s_reg.cfg1[C1_TXS_POS +: 10];
  assign cal_req    = s_reg.cfg1[C1_CAL_POS +: 4];
  assign trfc       = s_reg.cfg2[C2_TRFC_POS +: 10];
  assign row        = s_reg.cfg2[C2_ROW_POS +: 16];

  // derived timing
  logic [9:0] wl;
  logic [3:0] odt_len;
  logic [9:0] pd_wait;
  logic [3:0] cal_min;
  logic [3:0] cal_eff;
  logic [9:0] trfc_min;
  logic [9:0] ref_wait;
  logic       chop;

  assign chop = chop_fixed | chop_otf;
  assign wl   = 10'(cas_write_latency) + 10'(al) + 10'(pl);
  // ODT high time by burst kind and preamble
  assign odt_len = chop ? (pre2 ? 4'(ODTH4_2_CK) : 4'(ODTH4_1_CK))
                        : (pre2 ? 4'(ODTH8_2_CK) : 4'(ODTH8_1_CK));
  // internal write start offset decides the power-down wait
  assign pd_wait = wl + (chop_fixed ? 10'(BC4F_WR_CK)
                                    : 10'(BL8_WR_CK))
                 + 10'(wr) + 10'(PD_EXTRA_CK);
  // 1600 grade figures below 1600 MT/s
  assign cal_min  = slow ? 4'(CAL_MIN_1600) : 4'(CAL_MIN_OP);
  assign cal_eff  = (cal_req > cal_min) ? cal_req : cal_min;
  assign trfc_min = slow ? 10'(TRFC_MIN_1600)
                         : 10'(TRFC_MIN_OP);
  assign ref_wait = ((trfc > trfc_min) ? trfc : trfc_min)
                  + ((par_en && dll_off) ? 10'(pl) : 10'h000);

  // status word
  logic [31:0] status;

  always_comb begin
    status                 = 32'h0000_0000;
    status[ST_BUSY_POS]    = (s_reg.st != S_IDLE) || (s_reg.op_req != OP_NONE);
    status[ST_GEAR_POS]    = s_reg.gear_on;
    status[ST_WLS_POS]     = s_reg.wl_sample;
    status[ST_HAM_POS]     = s_reg.hammer;
    status[ST_CAL_POS +: 4] = cal_eff;
  end

  // apb decode, sequencer and pin drive
  always_comb begin
    logic acc;
    logic hit;
    logic hset;
    acc  = 1'b0;
    hit  = 1'b0;
    hset = 1'b0;
    s_next = s_reg;
    // leveling feedback synchroniser
    s_next.fb1 = ddr_dq_fb;
    s_next.fb2 = s_reg.fb1;

    // apb: answer on the second access cycle
    s_next.pready = psel && penable && !s_reg.pready;
    acc = psel && penable && s_reg.pready;
    hit = (paddr == REG_CTRL) || (paddr == REG_CFG0) ||
          (paddr == REG_CFG1) || (paddr == REG_CFG2) ||
          (paddr == REG_STATUS);
    if (psel && penable && !s_reg.pready) begin
      s_next.pslverr = !hit;
      unique case (paddr)
        REG_CFG0:   s_next.prdata = s_reg.cfg0;
        REG_CFG1:   s_next.prdata = s_reg.cfg1;
        REG_CFG2:   s_next.prdata = s_reg.cfg2;
        REG_STATUS: s_next.prdata = status;
        default:    s_next.prdata = 32'h0000_0000;
      endcase
    end
    if (acc && pwrite) begin
      unique case (paddr)
        REG_CTRL: begin
          if (!status[ST_BUSY_POS]) begin
            s_next.op_req = pwdata[CTRL_OP_POS +: 3];
          end
          if (pwdata[CTRL_HCLR_POS]) begin
            s_next.hammer = 1'b0;
          end
        end
        REG_CFG0: s_next.cfg0 = pwdata;
        REG_CFG1: s_next.cfg1 = pwdata;
        REG_CFG2: s_next.cfg2 = pwdata;
        default:  s_next.op_req = s_next.op_req;
      endcase
    end

    // everything on the link moves once per CK
    if (ck_rise) begin
      s_next.cs_n = 1'b1;
      s_next.cmd  = CMD_NOP;
      if (s_reg.tcnt != 10'h000) begin
        s_next.tcnt = s_reg.tcnt - 10'h001;
      end
      if (s_reg.cke && s_reg.since_cke != 10'h3FF) begin
        s_next.since_cke = s_reg.since_cke + 10'h001;
      end
      if (s_reg.odt_cnt != 4'h0) begin
        s_next.odt_cnt = s_reg.odt_cnt - 4'h1;
      end
      if (s_reg.odt_cnt == 4'h1) begin
        s_next.odt = 1'b0;
      end
      unique case (s_reg.st)
        S_IDLE: begin
          if (s_reg.op_req == OP_INIT) begin
            // leave reset, raise CKE and start tXPR
            s_next.rst_n     = 1'b1;
            s_next.cke       = 1'b1;
            s_next.since_cke = 10'h000;
            s_next.gear_on   = 1'b0;
            s_next.tcnt      = txpr;
            s_next.st        = S_XPR;
            s_next.op_req    = OP_NONE;
          end else if (s_reg.op_req != OP_NONE && !s_reg.cke) begin
            // wake from power-down first, keep the order pending
            s_next.cke       = 1'b1;
            s_next.since_cke = 10'h000;
          end else if (s_reg.op_req == OP_WLEV) begin
            s_next.cs_n   = 1'b0;
            s_next.cmd    = CMD_MRS;
            s_next.ba     = MR_LEVEL;
            s_next.addr   = 17'h00000;
            s_next.addr[MR1_WLEV_BIT] = 1'b1;
            s_next.tcnt   = 10'(WLDQSEN_CK);
            s_next.st     = S_WLEN;
            s_next.op_req = OP_NONE;
          end else if (s_reg.op_req == OP_WRITE) begin
            s_next.cs_n    = 1'b0;
            s_next.cmd     = CMD_WR;
            s_next.addr    = 17'h00000;
            s_next.addr[ADDR_AP_BIT] = auto_pre;
            s_next.odt     = 1'b1;
            s_next.odt_cnt = odt_len;
            s_next.tcnt    = pd_wait;
            s_next.st      = auto_pre ? S_PDW : S_ODT;
            s_next.op_req  = OP_NONE;
            // repeated hits on one row raise a sticky flag
            if (row == s_reg.last_row) begin
              if (s_reg.same_cnt != 4'hF) begin
                s_next.same_cnt = s_reg.same_cnt + 4'h1;
              end
              hset = (s_reg.same_cnt + 4'h1) >= 4'(HAMMER_LIM);
            end else begin
              s_next.same_cnt = 4'h0;
            end
            s_next.last_row = row;
          end else if (s_reg.op_req == OP_REF) begin
            s_next.cs_n   = 1'b0;
            s_next.cmd    = CMD_REF;
            s_next.tcnt   = ref_wait;
            s_next.st     = S_REFW;
            s_next.op_req = OP_NONE;
          end else begin
            s_next.op_req = OP_NONE;
          end
        end
        S_XPR: begin
          // gear-down prep MRS with CA latency, after tXPR
          if (s_reg.tcnt == 10'h000) begin
            s_next.cs_n = 1'b0;
            s_next.cmd  = CMD_MRS;
            s_next.ba   = MR_GEAR;
            s_next.addr = 17'h00000;
            s_next.addr[MR4_CAL_POS +: 4] = cal_eff;
            s_next.st   = S_TXS;
          end
        end
        S_TXS: begin
          if (s_reg.since_cke >= txs) begin
            s_next.cs_n = 1'b0;
            s_next.cmd  = CMD_MRS;
            s_next.ba   = MR_GEAR;
            s_next.addr = 17'h00000;
            s_next.addr[MR4_CAL_POS +: 4] = cal_eff;
            s_next.addr[MR3_GEAR_BIT] = 1'b1;
            s_next.tcnt = 10'(tmod) + 10'(GEAR_EXTRA_CK);
            s_next.st   = S_SYNCW;
          end
        end
        S_SYNCW: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.cs_n = 1'b0;                              // sync pulse
            s_next.st   = S_SYNC;
          end
        end
        S_SYNC: begin
          s_next.tcnt = 10'(tmod);
          s_next.st   = S_CMDW;
        end
        S_CMDW: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.gear_on = 1'b1;
            s_next.st      = S_IDLE;
          end
        end
        S_WLEN: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.dqs_oe = 1'b1;
            s_next.dqs    = 1'b0;
            s_next.tcnt   = 10'(WLMRD_CK - WLDQSEN_CK - 1);
            s_next.st     = S_WLEDGE;
          end
        end
        S_WLEDGE: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.dqs = 1'b1;
            s_next.st  = S_WLLOW;
          end
        end
        S_WLLOW: begin
          s_next.dqs  = 1'b0;
          s_next.tcnt = 10'(WL_SAMPLE_CK);
          s_next.st   = S_WLSAMP;
        end
        S_WLSAMP: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.wl_sample = s_reg.fb2;
            s_next.dqs_oe    = 1'b0;
            s_next.st        = S_IDLE;
          end
        end
        S_ODT: begin
          if (s_reg.odt_cnt == 4'h0) begin
            s_next.st = S_IDLE;
          end
        end
        S_PDW: begin
          // power-down only after the write recovery window
          if (s_reg.tcnt == 10'h000 && s_reg.odt_cnt == 4'h0) begin
            s_next.cke = 1'b0;
            s_next.st  = S_IDLE;
          end
        end
        S_REFW: begin
          if (s_reg.tcnt == 10'h000) begin
            s_next.st = S_IDLE;
          end
        end
        default: s_next.st = S_IDLE;
      endcase
    end
    // set wins over a clear in the same cycle
    if (hset) begin
      s_next.hammer = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg          <= '0;
      s_reg.st       <= S_IDLE;
      s_reg.cs_n     <= 1'b1;
      s_reg.cmd      <= CMD_NOP;
      s_reg.cfg0     <= CFG0_RST;
      s_reg.cfg1     <= CFG1_RST;
      s_reg.cfg2     <= CFG2_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata      = s_reg.prdata;
  assign pready      = s_reg.pready;
  assign pslverr     = s_reg.pslverr;
  assign ddr_reset_n = s_reg.rst_n;
  assign ddr_cke     = s_reg.cke;
  assign ddr_odt     = s_reg.odt;
  assign ddr_cs_n    = s_reg.cs_n;
  assign ddr_ras_n   = s_reg.cmd[2];
  assign ddr_cas_n   = s_reg.cmd[1];
  assign ddr_we_n    = s_reg.cmd[0];
  assign ddr_ba      = s_reg.ba;
  assign ddr_addr    = s_reg.addr;
  assign ddr_dqs_o   = s_reg.dqs;
  assign ddr_dqs_oe  = s_reg.dqs_oe;
endmodule

//--- dmt_pkg.sv
// Purpose: shared constants and the link clock divider for the DDR4
//          mode/timing sequencer.
// Assumes: clk_sys at 100 MHz; the sequencer makes CK itself by division.
// Notes:   all timing counts are in CK periods unless named _ps or _ns; CK_HALF_DEF is in system clocks.
// Functional notes
// - write with auto precharge: wait WL+2+WR+1 (fixed chop) before power-down.
// - ODT high at least 6 CK (1CK preamble) or 7 CK (2CK) for BL8 write.
// - ODT high at least 4/5 CK without write or with chop-4 write.
// - first rising DQS edge at least 40 CK after write leveling entry.
// - DQS drive enabled at least 25 CK after write leveling entry.
// - after reset exit with CKE high, wait tXPR before gear-down prep MRS.
// - CKE high to gear-down enable takes at least tXS.
// - gear-down enable MRS to sync pulse waits tMOD plus 4 CK.
// - sync pulse to first valid command waits at least tMOD.
// - parity on and DLL off: each refresh gets parity latency added.
// - CA latency at least max of 3 CK and 3.748 ns over tCK.
// - below 1600 MT/s use the 1600 grade timing values.
// - convert ns figures to clocks with the prescribed rounding method.
// - spread accesses over rows; repeated hits on one row are flagged.
`timescale 1ns/1ps

package dmt_pkg;
  // clocking
  localparam int SYS_PERIOD_PS = 10000;
  localparam int CK_HALF_DEF   = 4;
  localparam int TCK_PS        = 2 * CK_HALF_DEF * SYS_PERIOD_PS;
  localparam int TCK_1600_PS   = 1250;
  // register offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_CFG0   = 12'h004;
  localparam logic [11:0] REG_CFG1   = 12'h008;
  localparam logic [11:0] REG_CFG2   = 12'h00C;
  localparam logic [11:0] REG_STATUS = 12'h010;
  // CTRL fields
  localparam int CTRL_OP_POS    = 0;
  localparam int CTRL_HCLR_POS  = 3;
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_INIT  = 3'h1;
  localparam logic [2:0] OP_WLEV  = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_REF   = 3'h4;
  // CFG0 fields
  localparam int C0_CWL_POS   = 0;
  localparam int C0_AL_POS    = 5;
  localparam int C0_PL_POS    = 10;
  localparam int C0_WR_POS    = 14;
  localparam int C0_PRE2_POS  = 20;
  localparam int C0_CHOPF_POS = 21;
  localparam int C0_CHOPO_POS = 22;
  localparam int C0_PAR_POS   = 23;
  localparam int C0_DLLO_POS  = 24;
  localparam int C0_AP_POS    = 25;
  localparam int C0_SLOW_POS  = 26;
  localparam logic [31:0] CFG0_RST = 32'h0000_4009;
  // CFG1 fields
  localparam int C1_TMOD_POS = 0;
  localparam int C1_TXPR_POS = 8;
  localparam int C1_TXS_POS  = 18;
  localparam int C1_CAL_POS  = 28;
  localparam logic [31:0] CFG1_RST = 32'h0030_0818;
  // CFG2 fields
  localparam int C2_TRFC_POS = 0;
  localparam int C2_ROW_POS  = 16;
  localparam logic [31:0] CFG2_RST = 32'h0000_0010;
  // STATUS fields
  localparam int ST_BUSY_POS = 0;
  localparam int ST_GEAR_POS = 1;
  localparam int ST_WLS_POS  = 2;
  localparam int ST_HAM_POS  = 3;
  localparam int ST_CAL_POS  = 8;
  // command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_WR  = 3'h4;
  // mode register fields
  localparam logic [1:0] MR_LEVEL  = 2'h1;
  localparam logic [1:0] MR_GEAR   = 2'h3;
  localparam int MR1_WLEV_BIT = 7;
  localparam int MR3_GEAR_BIT = 3;
  localparam int MR4_CAL_POS  = 6;
  localparam int ADDR_AP_BIT  = 10;
  // timing counts
  localparam int ODTH8_1_CK  = 6;
  localparam int ODTH8_2_CK  = 7;
  localparam int ODTH4_1_CK  = 4;
  localparam int ODTH4_2_CK  = 5;
  localparam int WLMRD_CK    = 40;
  localparam int WLDQSEN_CK  = 25;
  localparam int GEAR_EXTRA_CK = 4;
  localparam int BL8_WR_CK   = 4;
  localparam int BC4F_WR_CK  = 2;
  localparam int PD_EXTRA_CK = 1;
  localparam int CAL_MIN_CK  = 3;
  localparam int CAL_MIN_PS  = 3748;
  localparam int TWLO_NS     = 10;
  localparam int WL_SAMPLE_CK =
    (TWLO_NS * 1000 + TCK_PS - 1) / TCK_PS + 1;
  localparam int TRFC_PS     = 350000;
  localparam int HAMMER_DEF  = 8;

  // non-SPD conversion: next higher whole clock
  function automatic int ceil_div(input int a, input int b);
    return (a + b - 1) / b;
  endfunction

  // SPD conversion: truncate(ps / tck + 0.974)
  function automatic int nck_spd(input int ps, input int tck);
    return (ps * 1000 + 974 * tck) / (tck * 1000);
  endfunction

  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // CA latency floors at the running clock and the 1600 grade
  localparam int CAL_MIN_OP =
    max_int(CAL_MIN_CK, ceil_div(CAL_MIN_PS, TCK_PS));
  localparam int CAL_MIN_1600 =
    max_int(CAL_MIN_CK, ceil_div(CAL_MIN_PS, TCK_1600_PS));
  localparam int TRFC_MIN_OP   = nck_spd(TRFC_PS, TCK_PS);
  localparam int TRFC_MIN_1600 = nck_spd(TRFC_PS, TCK_1600_PS);

  typedef enum logic [3:0] {
    S_IDLE, S_XPR, S_TXS, S_SYNCW, S_SYNC, S_CMDW,
    S_WLEN, S_WLEDGE, S_WLLOW, S_WLSAMP, S_ODT, S_PDW, S_REFW
  } dmt_state_type;
endpackage

// link clock divider: CK out and a pulse on each rising CK
module dmt_ckgen
  import dmt_pkg::*;
#(
  parameter int HALF = CK_HALF_DEF
) (
  // clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  // link clock
  output logic      ck,
  output logic      ck_rise
);
  typedef struct packed {
    logic [7:0] cnt;
    logic       ck;
    logic       rise;
  } dmt_ck_type;

  dmt_ck_type s_reg;
  dmt_ck_type s_next;

  // divider: toggle every HALF system clocks
  always_comb begin
    s_next      = s_reg;
    s_next.rise = 1'b0;
    if (s_reg.cnt == 8'(HALF - 1)) begin
      s_next.cnt  = 8'h00;
      s_next.ck   = ~s_reg.ck;
      s_next.rise = ~s_reg.ck;
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign ck      = s_reg.ck;
  assign ck_rise = s_reg.rise;
endmodule

//--- dmt_dram_model.sv
// Purpose: behavioural device side for leveling feedback
// Assumes: device drives its data line all the time
// Notes:   outside leveling the line toggles every cycle
`timescale 1ns/1ps

module dmt_dram_model (
  // link side
  input  wire logic clk_sys,
  input  wire logic ck,
  input  wire logic dqs,
  input  wire logic dqs_oe,
  // feedback
  output logic      dq_fb
);
  logic dqs_q = 1'b0;
  logic lev_q = 1'b0;
  logic fb_q  = 1'b0;
  assign dq_fb = fb_q;
  // ck level taken on each driven strobe rise
  always @(posedge clk_sys) begin
    dqs_q <= dqs & dqs_oe;
    if (dqs && dqs_oe && !dqs_q) begin
      lev_q <= ck;
    end
    fb_q <= dqs_oe ? lev_q : !fb_q;
  end
endmodule

//--- dmt_ctrl_asserts.sv
// Purpose: port checks of the DDR4 sequencer
// Assumes: CK_HALF of 4, a CK is 8 system cycles
// Notes:   config shadow follows APB writes
`timescale 1ns/1ps

module dmt_ctrl_asserts
  import dmt_pkg::*;
#(
  parameter int CK_HALF = CK_HALF_DEF
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // ddr
  input wire logic        ddr_cs_n,
  input wire logic        ddr_ras_n,
  input wire logic        ddr_cas_n,
  input wire logic        ddr_we_n,
  input wire logic [1:0]  ddr_ba,
  input wire logic        ddr_odt,
  input wire logic        ddr_dqs_o,
  input wire logic        ddr_dqs_oe
);
  localparam int CKS = 2 * CK_HALF;
  logic [31:0] cfg0_q;
  int          odt_c;
  int          wl_c;
  int          odt_len;
  logic        lev_mrs;
  // leveling mrs decode and expected odt length
  assign lev_mrs = !ddr_cs_n && ddr_ba == MR_LEVEL &&
    {ddr_ras_n, ddr_cas_n, ddr_we_n} == CMD_MRS;
  assign odt_len = int'(cfg0_q[C0_PRE2_POS]) +
    ((cfg0_q[C0_CHOPF_POS] | cfg0_q[C0_CHOPO_POS]) ? ODTH4_1_CK : ODTH8_1_CK);
  // shadow and elapsed-cycle counters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg0_q <= CFG0_RST;
      odt_c  <= 0;
      wl_c   <= 0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == REG_CFG0) begin
        cfg0_q <= pwdata;
      end
      odt_c <= ddr_odt ? odt_c + 1 : 0;
      wl_c  <= lev_mrs ? 0 : wl_c + 1;
    end
  end
  default clocking dmt_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  chk_apb_wait: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready) else $error("apb wait wrong");
  chk_apb_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  chk_apb_map: assert property (psel && penable && pready
    |-> pslverr == (paddr > REG_STATUS)) else $error("slave error wrong");
  chk_cmd_width: assert property ($fell(ddr_cs_n)
    |-> !ddr_cs_n [*8] ##1 ddr_cs_n) else $error("command width");
  chk_odt_hold: assert property ($fell(ddr_odt)
    |-> odt_c == odt_len * CKS) else $error("odt high time");
  chk_dqs_enable: assert property ($rose(ddr_dqs_oe)
    |-> wl_c + CKS >= WLDQSEN_CK * CKS) else $error("strobe enable early");
  chk_dqs_first: assert property ($rose(ddr_dqs_o)
    |-> ddr_dqs_oe && wl_c + CKS >= WLMRD_CK * CKS)
    else $error("first strobe early");
  chk_dqs_pulse: assert property ($rose(ddr_dqs_o)
    |-> ddr_dqs_o [*8] ##1 !ddr_dqs_o) else $error("strobe width");
  cov_odt: cover property ($fell(ddr_odt));
  cov_dqs: cover property ($rose(ddr_dqs_o));
  cov_err: cover property (pslverr);
endmodule

bind dmt_ctrl dmt_ctrl_asserts #(.CK_HALF(CK_HALF)) dmt_ctrl_asserts_i (
  .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
  .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba),
  .ddr_odt(ddr_odt), .ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe));

//--- dmt_ctrl_tb.sv
// Purpose: self-checking bench of the DDR4 sequencer
// Assumes: default parameters, CK of 80 ns
// Notes:   status is polled until idle after each order
`timescale 1ns/1ps

module dmt_ctrl_tb
  import dmt_pkg::*;
();
  typedef struct packed {
    logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic xe;
  } dmt_row_type;
  typedef struct packed {logic [31:0] c; int o; int p;} dmt_wr_type;
  localparam dmt_row_type ROWS [7] = '{
    '{REG_CFG0, 1'b0, 32'h0, CFG0_RST, 1'b0},
    '{REG_CFG1, 1'b0, 32'h0, CFG1_RST, 1'b0},
    '{REG_CFG2, 1'b0, 32'h0, CFG2_RST, 1'b0},
    '{REG_CFG2, 1'b1, 32'h0005_0020, 32'h0, 1'b0},
    '{REG_CFG2, 1'b0, 32'h0, 32'h0005_0020, 1'b0},
    '{REG_CTRL, 1'b0, 32'h0, 32'h0, 1'b0},
    '{12'h020, 1'b0, 32'h0, 32'h0, 1'b1}};
  localparam dmt_wr_type WRS [9] = '{
    '{32'h0000_4009, 6, 0}, '{32'h0010_4009, 7, 0},
    '{32'h0020_4009, 4, 0}, '{32'h0030_4009, 5, 0},
    '{32'h0200_4009, 6, 16}, '{32'h0220_4009, 4, 14},
    '{32'h0240_4009, 4, 16}, '{32'h0000_4009, 6, 0},
    '{32'h0010_4009, 7, 0}};
  localparam int CKS = 2 * CK_HALF_DEF;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        cke_q   = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e, ck, rst_n, cke, odt, cs_n, ras_n;
  logic        cas_n, we_n, dqs, dqs_oe, fb, wr_go;
  logic [1:0]  ba;
  logic [16:0] addr;
  logic [3:0]  cmd, cmd_q;
  int          errors = 0, n_checks = 0, cyc = 0;
  int          odt_n = 0, pd_t = 0, pd_got = 0, ref_n = 0, ref_t = 0;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  // first sample of a write command restarts the write counters
  assign wr_go = cmd == {1'b0, CMD_WR} && cmd_q != cmd;
  dmt_ctrl dmt_ctrl_i (
    .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ddr_ck(ck),
    .ddr_reset_n(rst_n), .ddr_cke(cke), .ddr_odt(odt), .ddr_cs_n(cs_n),
    .ddr_ras_n(ras_n), .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ba),
    .ddr_addr(addr), .ddr_dqs_o(dqs), .ddr_dqs_oe(dqs_oe), .ddr_dq_fb(fb));
  dmt_dram_model dmt_dram_model_i (
    .clk_sys(clk_sys), .ck(ck), .dqs(dqs), .dqs_oe(dqs_oe), .dq_fb(fb));
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // odt, write-to-power-down and refresh counts, plus run limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    cmd_q <= cmd;
    cke_q <= cke;
    odt_n <= wr_go ? 1 : odt ? odt_n + 1 : odt_n;
    pd_t <= wr_go ? 1 : pd_t + 1;
    if (cke_q && !cke) begin
      pd_got <= pd_t;
    end else if (wr_go) begin
      pd_got <= 0;
    end
    ref_t <= (cmd == {1'b0, CMD_REF} && cmd_q != cmd) ? 1 : ref_t + 1;
    if (cmd == {1'b0, CMD_REF} && cmd_q != cmd) begin
      ref_n <= ref_n + 1;
    end
    if (cyc == 20000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic order(input logic [2:0] op);
    int n;
    apb(REG_CTRL, 1'b1, 32'(op));
    repeat (2 * CKS) @(posedge clk_sys);
    for (n = 0; n < 900; n++) begin
      apb(REG_STATUS, 1'b0, 32'h0);
      if (q[ST_BUSY_POS] === 1'b0) begin
        break;
      end
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // register rows, then sequences and the refused order
  initial begin
    repeat (8) @(posedge clk_sys);
    chk("rst_n", 32'(rst_n), 32'h0);
    resetn <= 1'b1;
    @(posedge clk_sys);
    foreach (ROWS[i]) begin
      apb(ROWS[i].a, ROWS[i].w, ROWS[i].d);
      chk("slverr", 32'(e), 32'(ROWS[i].xe));
      if (!ROWS[i].w) begin
        chk("rdata", q, ROWS[i].x);
      end
    end
    order(OP_INIT);
    chk("gear", 32'(q[ST_GEAR_POS]), 32'h1);
    chk("cke", 32'(cke), 32'h1);
    chk("cal", 32'(q[ST_CAL_POS +: 4]), 32'(CAL_MIN_CK));
    order(OP_WLEV);
    chk("wl_sample", 32'(q[ST_WLS_POS]), 32'h1);
    foreach (WRS[i]) begin
      apb(REG_CFG0, 1'b1, WRS[i].c);
      order(OP_WRITE);
      chk("odt_len", odt_n, WRS[i].o * CKS);
      chk("pd_wait", pd_got, WRS[i].p * CKS);
    end
    chk("hammer", 32'(q[ST_HAM_POS]), 32'h1);
    // slow grade floor plus parity latency of 3 on refresh
    apb(REG_CFG0, 1'b1, 32'h0580_4C09);
    order(OP_REF);
    chk("ref", ref_t / CKS, TRFC_MIN_1600 + 4);
    apb(REG_CTRL, 1'b1, 32'(OP_WRITE));
    repeat (2 * CKS) @(posedge clk_sys);
    order(OP_REF);
    chk("refs", ref_n, 32'h1);
    end_of_test();
  end
endmodule
